// ### inc/dpt_map.vh
// Constants for the DDR3 termination and write-start timing block
// Functional notes
// - Termination follows control input after write latency minus 2 cycles.
// - In frozen power-down termination follows control within 2 to 8.5 ns; the block instead registers it, so it follows at the next clock edge.
// - Internal write starts 4 cycles after write latency, 2 for fixed chop four.
// - No maximum clock period beyond keeping the average refresh interval.
`ifndef DPT_MAP_VH
`define DPT_MAP_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define DPT_ADDR_CFG 4'h0
`define DPT_ADDR_STAT 4'h1
`define DPT_ADDR_WCNT 4'h2
// Config fields
`define DPT_CFG_CAS_LAT_LSB 0
`define DPT_CFG_ADD_LAT_LSB 4
`define DPT_CFG_FIX_CHOP_BIT 8
`define DPT_CFG_RST 16'h0005
// ----------------------------------------
// Timing
// ----------------------------------------
`define DPT_TERM_SUB 5'h02
`define DPT_OUT_STAGE 5'h01
`define DPT_WS_LONG 5'h04
`define DPT_WS_SHORT 5'h02
`define DPT_CLK_PS 100000
`define DPT_ASYNC_MIN_PS 2000
`define DPT_ASYNC_MAX_PS 8500
`endif

// ### design/dpt_delay_line.v
// Variable-length programmable delay of a one-bit level
`timescale 1ns/1ns
`default_nettype none
module dpt_delay_line (
	// Clock and reset
	input wire i_mclk,
	input wire i_rst,
	// Data
	input wire [4:0] i_delay,
	input wire i_d,
	output reg o_q
);
	reg [31:0] shift_reg;
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			shift_reg <= 32'h00000000;
			o_q <= 1'b0;
		end else begin
			shift_reg <= {shift_reg[30:0], i_d};
			// Zero delay passes the level through one flop
			if (i_delay == 5'h00) begin
				o_q <= i_d;
			end else begin
				o_q <= shift_reg[i_delay - 5'h01];
			end
		end
	end
endmodule
`default_nettype wire

// ### design/dpt_term_write.v
// DDR3 termination latency and internal write start timing
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "dpt_map.vh"
module dpt_term_write (
	// Clock and reset
	input wire i_mclk,
	input wire i_rst,
	// Register port
	input wire [3:0] i_addr,
	input wire [15:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [15:0] o_rdata,
	// Command side
	input wire i_termination_control,
	input wire i_write_cmd,
	input wire i_write_otf_chop,
	input wire i_powerdown_frozen,
	// Device outputs
	output reg o_termination_on,
	output reg o_write_start
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Difference clamped at zero, never wrapping
	function [4:0] sat_sub;
		input [4:0] a;
		input [4:0] b;
		begin
			sat_sub = (a > b) ? (a - b) : 5'h00;
		end
	endfunction

	// Delay-line tap for a latency counted from the sampling edge; the
	// output flop supplies the last cycle of every latency from 1 up; a latency of 0 still takes 1
	function [4:0] lat_tap;
		input [4:0] lat;
		begin
			lat_tap = sat_sub(lat, `DPT_OUT_STAGE);
		end
	endfunction

	// ----------------------------------------
	// Register write decode
	// ----------------------------------------
	wire cfg_we;

	assign cfg_we = i_wr && (i_addr == `DPT_ADDR_CFG);

	// ----------------------------------------
	// Configuration
	// ----------------------------------------
	reg [15:0] cfg_reg;
	reg [15:0] cfg_next;
	wire [4:0] cas_lat = {1'b0, cfg_reg[`DPT_CFG_CAS_LAT_LSB +: 4]};
	wire [4:0] add_lat = {1'b0, cfg_reg[`DPT_CFG_ADD_LAT_LSB +: 4]};
	wire fixed_chop = cfg_reg[`DPT_CFG_FIX_CHOP_BIT];
	// Sum of two four-bit fields always fits in five bits
	wire [4:0] wr_lat = cas_lat + add_lat;

	always @* begin
		cfg_next = cfg_reg;
		if (cfg_we) begin
			// Only the nine defined bits are kept
			cfg_next = {7'h00, i_wdata[8:0]};
		end
	end

	// ----------------------------------------
	// Latency arithmetic
	// ----------------------------------------
	// Latencies count edges, never time, so a slow clock is fine
	wire [4:0] term_lat = sat_sub(wr_lat, `DPT_TERM_SUB);
	wire [4:0] term_tap = lat_tap(term_lat);
	// Settings past the real latency range wrap; software keeps them sane
	wire [4:0] ws_long_lat = wr_lat + `DPT_WS_LONG;
	wire [4:0] ws_short_lat = wr_lat + `DPT_WS_SHORT;
	wire [4:0] ws_long_tap = lat_tap(ws_long_lat);
	wire [4:0] ws_short_tap = lat_tap(ws_short_lat);

	// ----------------------------------------
	// Write command classification
	// ----------------------------------------
	// Burst kind is decided at the command edge, so a chop input that
	// changes before the start cannot retime a write already in flight
	wire ws_short_cmd = i_write_cmd && fixed_chop && !i_write_otf_chop;
	wire ws_long_cmd = i_write_cmd && !ws_short_cmd;

	// ----------------------------------------
	// Delay lines
	// ----------------------------------------
	wire term_dly;
	wire ws_long_dly;
	wire ws_short_dly;

	dpt_delay_line u_term (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_delay(term_tap),
		.i_d(i_termination_control),
		.o_q(term_dly)
	);

	dpt_delay_line u_ws_long (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_delay(ws_long_tap),
		.i_d(ws_long_cmd),
		.o_q(ws_long_dly)
	);

	dpt_delay_line u_ws_short (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_delay(ws_short_tap),
		.i_d(ws_short_cmd),
		.o_q(ws_short_dly)
	);

	// ----------------------------------------
	// Termination output
	// ----------------------------------------
	// A registered pin cannot react inside the 2 to 8.5 ns window; the
	// frozen path answers at the next edge, the closest a flop can get
	localparam ASYNC_OK = (`DPT_ASYNC_MAX_PS < `DPT_CLK_PS);
	reg term_next;

	always @* begin
		if (i_powerdown_frozen && ASYNC_OK) begin
			term_next = i_termination_control;
		end else begin
			term_next = term_dly;
		end
	end

	// ----------------------------------------
	// Write start and counter
	// ----------------------------------------
	reg [15:0] wcnt_reg;
	reg [15:0] wcnt_next;
	wire ws_pulse = ws_long_dly | ws_short_dly;

	always @* begin
		wcnt_next = wcnt_reg;
		if (ws_pulse) begin
			// Wraps silently; software works with differences
			wcnt_next = wcnt_reg + 16'h0001;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	reg [15:0] rdata_next;
	wire [15:0] stat_word;

	assign stat_word = {14'h0000, i_powerdown_frozen,
		o_termination_on};

	always @* begin
		rdata_next = 16'h0000;
		if (i_rd) begin
			case (i_addr)
			`DPT_ADDR_CFG: begin
				rdata_next = cfg_reg;
			end
			`DPT_ADDR_STAT: begin
				rdata_next = stat_word;
			end
			`DPT_ADDR_WCNT: begin
				rdata_next = wcnt_reg;
			end
			default: begin
				// Unmapped offsets read as zero
				rdata_next = 16'h0000;
			end
			endcase
		end
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cfg_reg <= `DPT_CFG_RST;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			wcnt_reg <= 16'h0000;
		end else begin
			wcnt_reg <= wcnt_next;
		end
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 16'h0000;
		end else begin
			o_rdata <= rdata_next;
		end
	end

	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_termination_on <= 1'b0;
			o_write_start <= 1'b0;
		end else begin
			o_termination_on <= term_next;
			o_write_start <= ws_pulse;
		end
	end
endmodule
`default_nettype wire

// ### dv/dpt_props_properties.sv
// Timing checker for the termination and write-start block
`timescale 1ns/1ns
`default_nettype none
module dpt_props (
	input wire i_mclk, input wire i_rst,
	input wire [3:0] i_addr, input wire [15:0] i_wdata, input wire i_wr,
	input wire i_termination_control, input wire i_write_cmd,
	input wire i_write_otf_chop, input wire i_powerdown_frozen,
	input wire o_termination_on, input wire o_write_start
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	reg [8:0] cfg_reg;
	wire base_w = cfg_reg[7:0] == 8'h05;
	always @(posedge i_mclk or posedge i_rst)
		if (i_rst) cfg_reg <= 9'h005;
		else if (i_wr && i_addr == 4'h0) cfg_reg <= i_wdata[8:0];
	term_latency_a: assert property ((base_w && !i_powerdown_frozen) [*6]
		|-> o_termination_on == $past(i_termination_control, 4))
		else $error("termination latency wrong");
	async_term_a: assert property (i_powerdown_frozen [*2]
		|-> o_termination_on == $past(i_termination_control))
		else $error("frozen termination wrong");
	start_long_a: assert property (i_write_cmd && base_w
		&& (!cfg_reg[8] || i_write_otf_chop) |-> ##10 o_write_start)
		else $error("long write start late");
	start_short_a: assert property (i_write_cmd && base_w
		&& cfg_reg[8] && !i_write_otf_chop |-> ##8 o_write_start)
		else $error("short write start late");
	cover property (o_write_start);
	cover property (i_powerdown_frozen && o_termination_on);
	cover property (!i_powerdown_frozen && o_termination_on);
endmodule
`default_nettype wire

// ### dv/dpt_host_model.sv
// Host model issuing writes and termination control
`timescale 1ns/1ns
`default_nettype none
module dpt_host_model (
	input wire i_mclk, input wire i_rst, input wire i_go, input wire i_burst8,
	output logic o_termination_control, output logic o_write_cmd,
	output logic o_write_otf_chop
);
	reg [2:0] hold_reg;
	// Chop is held between writes; only its value beside the command counts
	// No refresh, mode set, leveling, read or power-down entry is issued,
	// so their spacing holds trivially
	always @(posedge i_mclk or posedge i_rst)
		if (i_rst) begin
			hold_reg <= 3'h0;
			o_termination_control <= 1'b0;
			o_write_cmd <= 1'b0;
			o_write_otf_chop <= 1'b0;
		end else begin
			o_write_cmd <= i_go;
			if (i_go) o_write_otf_chop <= ~i_burst8;
			if (i_go) hold_reg <= i_burst8 ? 3'h6 : 3'h4;
			else if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
			o_termination_control <= i_go | (hold_reg > 3'h1);
		end
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Testbench for the termination and write-start block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	reg i_mclk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	reg go = 1'b0, burst8 = 1'b0, frz = 1'b0;
	reg [3:0] addr = 4'h0;
	reg [15:0] wdata = 16'h0000;
	wire [15:0] rdata;
	wire term_ctl, wcmd, otf, term_on, wstart;
	integer num_errors = 0, checks_done = 0, cyc = 0;
	reg [3:0] term_hist = 4'h0;
	reg [9:0] long_hist = 10'h000, short_hist = 10'h000;
	reg frz_q = 1'b0, fixed_chop = 1'b0;
	wire term_exp, ws_exp;
	always #50 i_mclk = ~i_mclk;
	dpt_host_model dpt_host_model_inst (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_go(go), .i_burst8(burst8), .o_termination_control(term_ctl),
		.o_write_cmd(wcmd), .o_write_otf_chop(otf));
	dpt_term_write dpt_term_write_inst (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_addr(addr), .i_wdata(wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(rdata), .i_termination_control(term_ctl),
		.i_write_cmd(wcmd), .i_write_otf_chop(otf), .i_powerdown_frozen(frz),
		.o_termination_on(term_on), .o_write_start(wstart));
	task conclude; begin
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	end endtask
	task rd(input [3:0] a, input [15:0] exp); begin
		@(posedge i_mclk); addr <= a; i_rd <= 1'b1;
		@(posedge i_mclk); i_rd <= 1'b0; #1;
		checks_done = checks_done + 1;
		if (rdata !== exp) begin
			num_errors = num_errors + 1;
			$display("ERROR reg %h exp %h got %h", a, exp, rdata);
		end
	end endtask
	task wr(input [3:0] a, input [15:0] d); begin
		@(posedge i_mclk); addr <= a; wdata <= d; i_wr <= 1'b1;
		@(posedge i_mclk); i_wr <= 1'b0;
	end endtask
	task send(input b); begin
		@(posedge i_mclk); burst8 <= b; go <= 1'b1;
		@(posedge i_mclk); go <= 1'b0;
		repeat (16) @(posedge i_mclk);
	end endtask
	// Command-edge history of what the device samples
	always @(posedge i_mclk) begin
		term_hist <= {term_hist[2:0], term_ctl};
		long_hist <= {long_hist[8:0], wcmd & ~(fixed_chop & ~otf)};
		short_hist <= {short_hist[8:0], wcmd & fixed_chop & ~otf};
		frz_q <= frz;
	end
	// Cas write latency 5, additive 0: termination 3 edges after the
	// sample, write start 9 edges (7 with fixed chop four, no otf chop)
	assign term_exp = frz_q ? term_hist[0] : term_hist[3];
	assign ws_exp = long_hist[9] | short_hist[7];
	always @(negedge i_mclk) if (!i_rst) begin
		checks_done = checks_done + 2;
		if (term_on !== term_exp) begin
			num_errors = num_errors + 1;
			$display("ERROR term_on exp %b got %b", term_exp, term_on);
		end
		if (wstart !== ws_exp) begin
			num_errors = num_errors + 1;
			$display("ERROR write_start exp %b got %b", ws_exp, wstart);
		end
	end
	always @(posedge i_mclk) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			num_errors = num_errors + 1;
			conclude;
		end
	end
	initial begin
		repeat (8) @(posedge i_mclk);
		i_rst <= 1'b0;
		rd(4'h0, 16'h0005);
		send(1'b0);
		rd(4'h2, 16'h0001);
		wr(4'hF, 16'hFFFF);
		wr(4'h0, 16'h0105);
		fixed_chop = 1'b1;
		send(1'b1);
		rd(4'h2, 16'h0002);
		rd(4'hF, 16'h0000);
		@(posedge i_mclk); frz <= 1'b1;
		send(1'b0);
		rd(4'h1, 16'h0002);
		conclude;
	end
endmodule
bind dpt_term_write dpt_props dpt_props_inst (.i_mclk(i_mclk), .i_rst(i_rst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_termination_control(i_termination_control),
	.i_write_cmd(i_write_cmd), .i_write_otf_chop(i_write_otf_chop),
	.i_powerdown_frozen(i_powerdown_frozen),
	.o_termination_on(o_termination_on), .o_write_start(o_write_start));
`default_nettype wire
